// *** hdl/its_defs.svh ***
// Constants of the interrupt and trap system
`ifndef ITS_DEFS_SVH
`define ITS_DEFS_SVH
`define ITS_NODES     96
`define ITS_CHANS     8
`define ITS_GATES     4
`define ITS_RIN       4
`define ITS_ESRS      3
`define ITS_HWTRAPS   5
`define ITS_TRAPS     8
`define ITS_NODE_W    10
`define ITS_PTR_W     24
`define ITS_CC_W      12
`define ITS_VEC_W     7
// Node control fields
`define ITS_F_REQ     0
`define ITS_F_EN      1
`define ITS_F_PRIO    2
`define ITS_PRIO_W    4
`define ITS_F_XFER    6
`define ITS_F_CH      7
// Channel control fields
`define ITS_C_CNT     0
`define ITS_CNT_W     8
`define ITS_C_WORD    8
`define ITS_C_INCS    9
`define ITS_C_INCD    10
`define ITS_C_CONT    11
// Router and gate fields
`define ITS_RC_W      4
`define ITS_RC_RISE   0
`define ITS_RC_FALL   1
`define ITS_RC_GSEL   2
`define ITS_GC_W      6
`define ITS_GC_EN     4
`define ITS_GC_MISS   5
`define ITS_SS_W      2
// Node numbers fed by router and by shared sources
`define ITS_RTR_LO    88
`define ITS_SHR_LO    92
// Channel page number, then byte offsets
`define ITS_CH_PAGE   5'h04
`define ITS_A_SSEL    12'h280
`define ITS_A_RCFG    12'h284
`define ITS_A_GCFG    12'h288
`define ITS_A_TFR     12'h28C
`define ITS_A_STAT    12'h290
// Response latency in clock cycles, then pointer increments of byte and word transfers
`define ITS_LAT_CACHE   7
`define ITS_LAT_NOCACHE 11
`define ITS_INC_B     24'h00_0001
`define ITS_INC_W     24'h00_0002
`endif

// *** hdl/its_pkg.sv ***
// Types of the interrupt and trap system
`include "its_defs.svh"
package its_pkg;
   typedef enum logic {ST_IDLE, ST_WAIT} its_state_type;
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [11:0] adr;
      logic [31:0] dat;
   } its_wb_type;
   typedef struct packed {
      logic                  valid;
      logic                  trap;
      logic [`ITS_VEC_W-1:0] vec;
   } its_branch_type;
   typedef struct packed {
      logic                  valid;
      logic                  word;
      logic [`ITS_PTR_W-1:0] src;
      logic [`ITS_PTR_W-1:0] dst;
   } its_xfer_type;
endpackage

// *** hdl/its_top.sv ***
// Interrupt nodes, event transfer channels, request router, traps and bus slave
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`include "its_defs.svh"
// Function
// - Node bit selects standard interrupt or event transfer channel service.
// - Standard service issues a branch to the node's vector entry.
// - Event transfer takes one stall cycle, no branch.
// - Transfer moves byte or word, optionally bumps source and destination pointers.
// - Transfer counter decrements per service unless continuous mode.
// - Counter reaching zero raises standard interrupt of the same node.
// - Eight independent transfer channels.
// - Branch follows request after 7 clocks with jump cache, 11 without.
// - 96 nodes, each with request flag, enable flag and priority.
// - Shared nodes take the source chosen in the source select register.
// - Four router inputs detect rising, falling or both edges.
// - Four gating units combine routed events, gated by pattern match or miss.
// - Hardware trap branches to its own trap vector.
// - Each hardware or service request trap sets its own bit in the trap flag register; a software trap sets none.
// - Trap preempts anything unless an equal or higher trap is in service.
// - Interrupts and transfers wait while a trap is in service.
// - Three service request pins raise system request traps.
// - Software trap number branches to that trap vector.
// - Software setting a request flag acts like a hardware request.
module its_top (
   input  wire logic                    clock,
   input  wire logic                    sys_rst,
   input  its_pkg::its_wb_type          wb_i,
   output logic [31:0]                  wb_dat_o,
   output logic                         wb_ack_o,
   input  wire logic [`ITS_NODES-1:0]   node_src,
   input  wire logic [15:0]             alt_src,
   input  wire logic [`ITS_RIN-1:0]     router_pin,
   input  wire logic [`ITS_ESRS-1:0]    esr_pin,
   input  wire logic [`ITS_HWTRAPS-1:0] hw_trap,
   input  wire logic                    sw_trap_valid,
   input  wire logic [`ITS_VEC_W-1:0]   sw_trap_num,
   input  wire logic                    jump_cache,
   input  wire logic                    svc_done,
   output its_pkg::its_branch_type      branch_o,
   output its_pkg::its_xfer_type        xfer_o,
   output logic                         cpu_stall
);
   import its_pkg::*;

   localparam int LAT_C_D = `ITS_LAT_CACHE - 1;
   // Tail after the eight quiet cycles that the no-cache latency check counts first
   localparam int LAT_N_D = `ITS_LAT_NOCACHE - 8;

   logic [`ITS_NODE_W-1:0] node_r [`ITS_NODES];
   logic [`ITS_NODE_W-1:0] node_nxt [`ITS_NODES];
   logic [`ITS_PTR_W-1:0]  src_r [`ITS_CHANS];
   logic [`ITS_PTR_W-1:0]  src_nxt [`ITS_CHANS];
   logic [`ITS_PTR_W-1:0]  dst_r [`ITS_CHANS];
   logic [`ITS_PTR_W-1:0]  dst_nxt [`ITS_CHANS];
   logic [`ITS_CC_W-1:0]   cc_r [`ITS_CHANS];
   logic [`ITS_CC_W-1:0]   cc_nxt [`ITS_CHANS];
   logic [7:0]             ssel_r, ssel_nxt;
   logic [15:0]            rcfg_r, rcfg_nxt;
   logic [23:0]            gcfg_r, gcfg_nxt;
   logic [`ITS_TRAPS-1:0]  tfr_r, tfr_nxt;
   logic [`ITS_TRAPS-1:0]  tpend_r, tpend_nxt;
   logic                   swp_r, swp_nxt;
   logic [`ITS_VEC_W-1:0]  swn_r, swn_nxt;
   its_state_type          st_r, st_nxt;
   logic [3:0]             cnt_r, cnt_nxt;
   logic [`ITS_VEC_W-1:0]  pvec_r, pvec_nxt;
   logic                   ptrap_r, ptrap_nxt;
   logic                   tact_r, tact_nxt;
   logic [2:0]             tlvl_r, tlvl_nxt;
   logic                   iact_r, iact_nxt;
   logic [`ITS_PRIO_W-1:0] ipri_r, ipri_nxt;
   its_branch_type         br_r, br_nxt;
   its_xfer_type           xf_r, xf_nxt;
   logic                   ack_r, ack_nxt;
   logic [31:0]            rdat_r, rdat_nxt;
   logic [`ITS_RIN-1:0]    rs1_r, rs2_r, rs3_r;
   logic [`ITS_ESRS-1:0]   es1_r, es2_r, es3_r;
   logic [`ITS_RIN-1:0]    rev;
   logic [`ITS_GATES-1:0]  gev;
   logic [`ITS_NODES-1:0]  hw_set;
   logic [`ITS_TRAPS-1:0]  trap_set;
   logic                   win_v;
   logic [`ITS_VEC_W-1:0]  win_i;
   logic [`ITS_PRIO_W-1:0] win_p;
   logic                   tp_v;
   logic [2:0]             tp_i;
   logic                   acc_v, acc_std, xfer_go;
   logic                   wb_go;
   logic [9:0]             widx;
   logic [11:0]            wadr;
   logic                   is_node, is_ch;
   logic [2:0]             wch;
   logic [1:0]             wsub;
   logic [31:0]            rv;

   // Byte lanes of a write merged into the old word
   function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] m;
      m = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) m[8*b +: 8] = d[8*b +: 8];
      end
      return m;
   endfunction

   // Pins pass two stages; the third only keeps the last level for edges
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rs1_r <= '0;
         rs2_r <= '0;
         rs3_r <= '0;
         es1_r <= '0;
         es2_r <= '0;
         es3_r <= '0;
      end else begin
         rs1_r <= router_pin;
         rs2_r <= rs1_r;
         rs3_r <= rs2_r;
         es1_r <= esr_pin;
         es2_r <= es1_r;
         es3_r <= es2_r;
      end
   end

   always_comb begin
      rev = '0;
      for (int i = 0; i < `ITS_RIN; i++) begin
         rev[i] = (rcfg_r[`ITS_RC_W*i+`ITS_RC_RISE] & rs2_r[i] & ~rs3_r[i])
                | (rcfg_r[`ITS_RC_W*i+`ITS_RC_FALL] & ~rs2_r[i] & rs3_r[i]);
      end
   end

   for (genvar g = 0; g < `ITS_GATES; g++) begin : gate
      logic [`ITS_GC_W-1:0] gc;
      logic                 evs;
      logic                 hitm;
      assign gc   = gcfg_r[`ITS_GC_W*g +: `ITS_GC_W];
      // Pattern is met when every masked input level is high
      assign hitm = &(rs2_r | ~gc[`ITS_RIN-1:0]);
      always_comb begin
         evs = 1'b0;
         for (int i = 0; i < `ITS_RIN; i++) begin
            if (rcfg_r[`ITS_RC_W*i+`ITS_RC_GSEL +: 2] == 2'(g)) evs = evs | rev[i];
         end
      end
      assign gev[g] = gc[`ITS_GC_EN] & evs & (gc[`ITS_GC_MISS] ? ~hitm : hitm);
   end

   always_comb begin
      hw_set = node_src;
      for (int k = 0; k < `ITS_GATES; k++) begin
         hw_set[`ITS_RTR_LO+k] = node_src[`ITS_RTR_LO+k] | gev[k];
      end
      // Dedicated line of a shared node is ignored; the selection decides
      for (int k = 0; k < 4; k++) begin
         hw_set[`ITS_SHR_LO+k] = alt_src[4*k + int'(ssel_r[`ITS_SS_W*k +: `ITS_SS_W])];
      end
   end

   assign trap_set = {es2_r & ~es3_r, hw_trap};

   // Ties go to the lowest node number
   always_comb begin
      win_v = 1'b0;
      win_i = '0;
      win_p = '0;
      for (int n = 0; n < `ITS_NODES; n++) begin
         if (node_r[n][`ITS_F_REQ] && node_r[n][`ITS_F_EN]
             && (!win_v || node_r[n][`ITS_F_PRIO +: `ITS_PRIO_W] > win_p)) begin
            win_v = 1'b1;
            win_i = `ITS_VEC_W'(n);
            win_p = node_r[n][`ITS_F_PRIO +: `ITS_PRIO_W];
         end
      end
   end

   // Lower trap number is the higher priority
   always_comb begin
      tp_v = |tpend_r;
      tp_i = '0;
      for (int t = `ITS_TRAPS - 1; t >= 0; t--) begin
         if (tpend_r[t]) tp_i = 3'(t);
      end
   end

   assign wb_go   = wb_i.cyc & wb_i.stb & ack_r;
   assign widx    = wb_i.adr[11:2];
   assign wadr    = {widx, 2'b00};
   assign is_node = widx < 10'(`ITS_NODES);
   assign is_ch   = wb_i.adr[11:7] == `ITS_CH_PAGE;
   assign wch     = widx[4:2];
   assign wsub    = widx[1:0];

   always_comb begin
      rv = '0;
      if (is_node) rv[`ITS_NODE_W-1:0] = node_r[widx[6:0]];
      else if (is_ch) begin
         case (wsub)
            2'h0:    rv[`ITS_PTR_W-1:0] = src_r[wch];
            2'h1:    rv[`ITS_PTR_W-1:0] = dst_r[wch];
            2'h2:    rv[`ITS_CC_W-1:0] = cc_r[wch];
            default: rv = '0;
         endcase
      end
      else if (wadr == `ITS_A_SSEL) rv[7:0] = ssel_r;
      else if (wadr == `ITS_A_RCFG) rv[15:0] = rcfg_r;
      else if (wadr == `ITS_A_GCFG) rv[23:0] = gcfg_r;
      else if (wadr == `ITS_A_TFR) rv[`ITS_TRAPS-1:0] = tfr_r;
      else if (wadr == `ITS_A_STAT) rv[9:0] = {tlvl_r, tact_r, ipri_r, iact_r, st_r == ST_WAIT};
   end

   always_comb begin
      logic [2:0]             ch;
      logic [`ITS_CC_W-1:0]   c;
      logic [`ITS_PTR_W-1:0]  inc;
      ch = '0;
      c = '0;
      inc = '0;
      node_nxt = node_r;
      src_nxt = src_r;
      dst_nxt = dst_r;
      cc_nxt = cc_r;
      ssel_nxt = ssel_r;
      rcfg_nxt = rcfg_r;
      gcfg_nxt = gcfg_r;
      tfr_nxt = tfr_r;
      tpend_nxt = tpend_r;
      swp_nxt = swp_r;
      swn_nxt = swn_r;
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      pvec_nxt = pvec_r;
      ptrap_nxt = ptrap_r;
      tact_nxt = tact_r;
      tlvl_nxt = tlvl_r;
      iact_nxt = iact_r;
      ipri_nxt = ipri_r;
      br_nxt = '0;
      xf_nxt = '0;
      acc_v = 1'b0;
      acc_std = 1'b0;
      xfer_go = 1'b0;
      ack_nxt = wb_i.cyc & wb_i.stb & ~ack_r;
      rdat_nxt = ack_nxt ? rv : rdat_r;
      // One level of nesting only: a return ends the trap first, else the interrupt
      if (svc_done) begin
         if (tact_r) tact_nxt = 1'b0;
         else iact_nxt = 1'b0;
      end
      case (st_r)
         ST_IDLE: begin
            if (tp_v && (!tact_r || tp_i < tlvl_r)) begin
               tpend_nxt[tp_i] = 1'b0;
               tact_nxt = 1'b1;
               tlvl_nxt = tp_i;
               pvec_nxt = `ITS_VEC_W'(tp_i);
               ptrap_nxt = 1'b1;
               st_nxt = ST_WAIT;
               cnt_nxt = jump_cache ? 4'(`ITS_LAT_CACHE - 3) : 4'(`ITS_LAT_NOCACHE - 3);
            end else if (swp_r && !tact_r) begin
               swp_nxt = 1'b0;
               pvec_nxt = swn_r;
               ptrap_nxt = 1'b1;
               st_nxt = ST_WAIT;
               cnt_nxt = jump_cache ? 4'(`ITS_LAT_CACHE - 3) : 4'(`ITS_LAT_NOCACHE - 3);
            end else if (win_v && !tact_r && (!iact_r || win_p > ipri_r)) begin
               acc_v = 1'b1;
               node_nxt[win_i][`ITS_F_REQ] = 1'b0;
               acc_std = 1'b1;
               if (node_r[win_i][`ITS_F_XFER]) begin
                  ch = node_r[win_i][`ITS_F_CH +: 3];
                  c = cc_r[ch];
                  if (c[`ITS_C_CNT +: `ITS_CNT_W] != '0 || c[`ITS_C_CONT]) begin
                     xfer_go = 1'b1;
                     inc = c[`ITS_C_WORD] ? `ITS_INC_W : `ITS_INC_B;
                     xf_nxt = {1'b1, c[`ITS_C_WORD], src_r[ch], dst_r[ch]};
                     if (c[`ITS_C_INCS]) src_nxt[ch] = src_r[ch] + inc;
                     if (c[`ITS_C_INCD]) dst_nxt[ch] = dst_r[ch] + inc;
                     if (!c[`ITS_C_CONT]) begin
                        cc_nxt[ch][`ITS_C_CNT +: `ITS_CNT_W] = c[`ITS_C_CNT +: `ITS_CNT_W] - 8'h01;
                     end
                     // Only the last transfer of a block also wakes the handler
                     acc_std = !c[`ITS_C_CONT] && c[`ITS_C_CNT +: `ITS_CNT_W] == 8'h01;
                  end
               end
               if (acc_std) begin
                  iact_nxt = 1'b1;
                  ipri_nxt = win_p;
                  pvec_nxt = win_i;
                  ptrap_nxt = 1'b0;
                  st_nxt = ST_WAIT;
                  cnt_nxt = jump_cache ? 4'(`ITS_LAT_CACHE - 3) : 4'(`ITS_LAT_NOCACHE - 3);
               end
            end
         end
         ST_WAIT: begin
            if (cnt_r == '0) begin
               br_nxt = {1'b1, ptrap_r, pvec_r};
               st_nxt = ST_IDLE;
            end else cnt_nxt = cnt_r - 4'h1;
         end
         default: st_nxt = ST_IDLE;
      endcase
      // Software writes after the service clear, so a written request flag stands
      if (wb_go && wb_i.we) begin
         if (is_node) begin
            node_nxt[widx[6:0]] = `ITS_NODE_W'(bmerge(32'(node_r[widx[6:0]]), wb_i.dat, wb_i.sel));
         end else if (is_ch) begin
            case (wsub)
               2'h0:    src_nxt[wch] = `ITS_PTR_W'(bmerge(32'(src_r[wch]), wb_i.dat, wb_i.sel));
               2'h1:    dst_nxt[wch] = `ITS_PTR_W'(bmerge(32'(dst_r[wch]), wb_i.dat, wb_i.sel));
               2'h2:    cc_nxt[wch] = `ITS_CC_W'(bmerge(32'(cc_r[wch]), wb_i.dat, wb_i.sel));
               default: cc_nxt[wch] = cc_r[wch];
            endcase
         end
         else if (wadr == `ITS_A_SSEL) ssel_nxt = 8'(bmerge(32'(ssel_r), wb_i.dat, wb_i.sel));
         else if (wadr == `ITS_A_RCFG) rcfg_nxt = 16'(bmerge(32'(rcfg_r), wb_i.dat, wb_i.sel));
         else if (wadr == `ITS_A_GCFG) gcfg_nxt = 24'(bmerge(32'(gcfg_r), wb_i.dat, wb_i.sel));
         else if (wadr == `ITS_A_TFR) begin
            tfr_nxt = tfr_r & ~`ITS_TRAPS'(bmerge(32'h0000_0000, wb_i.dat, wb_i.sel));
         end
      end
      // Hardware sets win over every clear in the same cycle
      for (int n = 0; n < `ITS_NODES; n++) begin
         if (hw_set[n]) node_nxt[n][`ITS_F_REQ] = 1'b1;
      end
      tfr_nxt = tfr_nxt | trap_set;
      tpend_nxt = tpend_nxt | trap_set;
      if (sw_trap_valid) begin
         swp_nxt = 1'b1;
         swn_nxt = sw_trap_num;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         for (int n = 0; n < `ITS_NODES; n++) node_r[n] <= '0;
         for (int k = 0; k < `ITS_CHANS; k++) begin
            src_r[k] <= '0;
            dst_r[k] <= '0;
            cc_r[k] <= '0;
         end
         ssel_r <= '0;
         rcfg_r <= '0;
         gcfg_r <= '0;
         tfr_r <= '0;
         tpend_r <= '0;
         swp_r <= 1'b0;
         swn_r <= '0;
         st_r <= ST_IDLE;
         cnt_r <= '0;
         pvec_r <= '0;
         ptrap_r <= 1'b0;
         tact_r <= 1'b0;
         tlvl_r <= '0;
         iact_r <= 1'b0;
         ipri_r <= '0;
         br_r <= '0;
         xf_r <= '0;
         ack_r <= 1'b0;
         rdat_r <= '0;
      end else begin
         node_r <= node_nxt;
         src_r <= src_nxt;
         dst_r <= dst_nxt;
         cc_r <= cc_nxt;
         ssel_r <= ssel_nxt;
         rcfg_r <= rcfg_nxt;
         gcfg_r <= gcfg_nxt;
         tfr_r <= tfr_nxt;
         tpend_r <= tpend_nxt;
         swp_r <= swp_nxt;
         swn_r <= swn_nxt;
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         pvec_r <= pvec_nxt;
         ptrap_r <= ptrap_nxt;
         tact_r <= tact_nxt;
         tlvl_r <= tlvl_nxt;
         iact_r <= iact_nxt;
         ipri_r <= ipri_nxt;
         br_r <= br_nxt;
         xf_r <= xf_nxt;
         ack_r <= ack_nxt;
         rdat_r <= rdat_nxt;
      end
   end

   assign wb_dat_o  = rdat_r;
   assign wb_ack_o  = ack_r;
   assign branch_o  = br_r;
   assign xfer_o    = xf_r;
   assign cpu_stall = xf_r.valid;

   a_xfer_single: assert property (@(posedge clock) disable iff (sys_rst)
      xfer_go |=> (xf_r.valid && cpu_stall && !br_r.valid) ##1 !xf_r.valid)
      else $error("transfer did not take exactly one stall cycle");
   a_lat_cache: assert property (@(posedge clock) disable iff (sys_rst)
      (acc_std && jump_cache) |-> ##LAT_C_D (branch_o.valid && !branch_o.trap))
      else $error("interrupt branch latency with jump cache wrong");
   a_lat_nocache: assert property (@(posedge clock) disable iff (sys_rst)
      (acc_std && !jump_cache) |-> !branch_o.valid [*8] ##LAT_N_D branch_o.valid)
      else $error("interrupt branch latency without jump cache wrong");
   a_tfr_set: assert property (@(posedge clock) disable iff (sys_rst)
      (hw_trap != '0) |=> ((tfr_r[`ITS_HWTRAPS-1:0] & $past(hw_trap)) == $past(hw_trap)))
      else $error("trap flag not set by trap event");
   a_trap_block: assert property (@(posedge clock) disable iff (sys_rst)
      tact_r |-> !acc_v && !xfer_go)
      else $error("interrupt or transfer accepted during trap service");
   a_grant_clear: assert property (@(posedge clock) disable iff (sys_rst)
      (acc_v && !hw_set[win_i] && !(wb_go && wb_i.we && is_node)) |=> !node_r[$past(win_i)][`ITS_F_REQ])
      else $error("request flag not cleared on acceptance");
   a_sw_request: assert property (@(posedge clock) disable iff (sys_rst)
      (wb_go && wb_i.we && is_node && wb_i.sel[0] && wb_i.dat[`ITS_F_REQ]) |=> node_r[$past(widx[6:0])][`ITS_F_REQ])
      else $error("software request flag write lost");
   a_count_dec: assert property (@(posedge clock) disable iff (sys_rst)
      (xfer_go && !cc_r[node_r[win_i][`ITS_F_CH +: 3]][`ITS_C_CONT] && !(wb_go && wb_i.we && is_ch))
      |=> cc_r[$past(node_r[win_i][`ITS_F_CH +: 3])][`ITS_CNT_W-1:0]
          == $past(cc_r[node_r[win_i][`ITS_F_CH +: 3]][`ITS_CNT_W-1:0]) - 8'h01)
      else $error("transfer counter not decremented");
   a_zero_int: assert property (@(posedge clock) disable iff (sys_rst)
      (xfer_go && acc_std) |=> (st_r == ST_WAIT && !ptrap_r && pvec_r == $past(win_i)))
      else $error("counter zero did not raise node interrupt");
   a_trap_branch: assert property (@(posedge clock) disable iff (sys_rst)
      (st_r == ST_IDLE && tp_v && !tact_r) |-> ##[6:10] (branch_o.valid && branch_o.trap))
      else $error("hardware trap did not branch to trap vector");
endmodule

// *** bench/its_cpu_model.sv ***
// CPU core stand-in that returns from each handler after a fixed delay
`timescale 1ns/10ps
module its_cpu_model
   #(parameter int RET_DLY = 4)
   (
   input  wire logic               clock,
   input  wire logic               sys_rst,
   input  its_pkg::its_branch_type branch_o,
   output logic                    svc_done
);
   import its_pkg::*;
   logic [3:0] depth_r;
   logic [3:0] depth_nxt;
   logic [7:0] wait_r;
   logic [7:0] wait_nxt;
   logic       done_nxt;
   // Nesting depth counts open handlers, so a trap over an interrupt returns twice
   always_comb begin
      depth_nxt = depth_r;
      wait_nxt  = wait_r;
      done_nxt  = 1'b0;
      if (branch_o.valid) begin
         depth_nxt = depth_r + 4'h1;
         wait_nxt  = 8'(RET_DLY);
      end else if (wait_r != 8'h00) begin
         wait_nxt = wait_r - 8'h01;
      end else if (depth_r != 4'h0) begin
         done_nxt  = 1'b1;
         depth_nxt = depth_r - 4'h1;
         wait_nxt  = 8'(RET_DLY);
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         depth_r  <= '0;
         wait_r   <= '0;
         svc_done <= 1'b0;
      end else begin
         depth_r  <= depth_nxt;
         wait_r   <= wait_nxt;
         svc_done <= done_nxt;
      end
   end
endmodule

// *** bench/its_bench.sv ***
// Self-checking bench of the interrupt and trap system
`timescale 1ns/10ps
`include "its_defs.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module interrupt_and_trap_system_bench;
   import its_pkg::*;
   typedef struct {int node; logic jc; int lat;} its_row_type;
   logic           clock, sys_rst, sw_trap_valid, jump_cache, svc_done, wb_ack_o, cpu_stall;
   logic [31:0]    wb_dat_o, rd;
   logic [95:0]    node_src;
   logic [15:0]    alt_src;
   logic [3:0]     router_pin;
   logic [2:0]     esr_pin;
   logic [4:0]     hw_trap;
   logic [6:0]     sw_trap_num;
   its_wb_type     wb_i;
   its_branch_type branch_o;
   its_xfer_type   xfer_o;
   int             errors = 0, n_compared = 0, cycles = 0, n = 0;
   its_row_type    rows [4] = '{'{3, 1'b1, `ITS_LAT_CACHE}, '{40, 1'b0, `ITS_LAT_NOCACHE},
                                '{87, 1'b1, `ITS_LAT_CACHE}, '{0, 1'b0, `ITS_LAT_NOCACHE}};
   its_top dut_u (.clock, .sys_rst, .wb_i, .wb_dat_o, .wb_ack_o, .node_src, .alt_src, .router_pin,
      .esr_pin, .hw_trap, .sw_trap_valid, .sw_trap_num, .jump_cache, .svc_done, .branch_o, .xfer_o,
      .cpu_stall);
   its_cpu_model #(.RET_DLY(4)) cpu_u (.clock, .sys_rst, .branch_o, .svc_done);
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clock);
      wb_i <= '{1'b1, 1'b1, we, 4'hf, a, d};
      do @(posedge clock); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_i <= '0;
   endtask
   task automatic fire(input logic [95:0] m, input logic [4:0] t);
      @(posedge clock);
      node_src <= m;
      hw_trap  <= t;
      @(posedge clock);
      node_src <= '0;
      hw_trap  <= '0;
   endtask
   // Counts edges after the pulse edge; bounded so a lost event cannot hang
   task automatic wait_ev(input logic xf, output int k);
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while ((xf ? xfer_o.valid : branch_o.valid) !== 1'b1 && k < 60);
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 6000) begin
         errors++;
         end_of_test();
      end
   end
   initial begin
      sys_rst       = 1'b1;
      wb_i          = '0;
      node_src      = '0;
      alt_src       = '0;
      router_pin    = '0;
      esr_pin       = '0;
      hw_trap       = '0;
      sw_trap_valid = 1'b0;
      sw_trap_num   = '0;
      jump_cache    = 1'b1;
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      wb(1'b0, 12'h290, '0, rd);
      `CHK(rd, 32'h0000_0000)
      wb(1'b0, 12'h2a0, '0, rd);
      `CHK(rd, 32'h0000_0000)
      $display("reset test done");
      foreach (rows[i]) begin
         jump_cache <= rows[i].jc;
         wb(1'b1, 12'(4 * rows[i].node), 32'h0000_0006, rd);
         fire(96'h1 << rows[i].node, 5'h00);
         wait_ev(1'b0, n);
         `CHK(n, rows[i].lat)
         `CHK({branch_o.trap, branch_o.vec}, 8'(rows[i].node))
         wb(1'b0, 12'(4 * rows[i].node), '0, rd);
         `CHK(rd, 32'h0000_0006)
         repeat (8) @(posedge clock);
      end
      $display("row test done");
      jump_cache <= 1'b1;
      wb(1'b1, 12'h270, 32'h0000_0100, rd);
      wb(1'b1, 12'h274, 32'h0000_0200, rd);
      wb(1'b1, 12'h278, 32'h0000_0702, rd);
      wb(1'b1, 12'h014, 32'h0000_03c6, rd);
      for (int k = 0; k < 2; k++) begin
         fire(96'h20, 5'h00);
         wait_ev(1'b1, n);
         `CHK(n, 2)
         `CHK({cpu_stall, xfer_o.word}, 2'b11)
         `CHK(xfer_o.src, 24'h00_0100 + 24'(2 * k))
         `CHK(xfer_o.dst, 24'h00_0200 + 24'(2 * k))
      end
      wait_ev(1'b0, n);
      `CHK(n, `ITS_LAT_CACHE - 2)
      `CHK({branch_o.trap, branch_o.vec}, 8'h05)
      wb(1'b0, 12'h278, '0, rd);
      `CHK(rd, 32'h0000_0700)
      $display("transfer test done");
      repeat (8) @(posedge clock);
      fire(96'h8, 5'h02);
      wait_ev(1'b0, n);
      `CHK(n, `ITS_LAT_CACHE)
      `CHK({branch_o.trap, branch_o.vec}, 8'h81)
      wait_ev(1'b0, n);
      `CHK({branch_o.trap, branch_o.vec}, 8'h03)
      wb(1'b0, 12'h28c, '0, rd);
      `CHK(rd, 32'h0000_0002)
      wb(1'b1, 12'h28c, 32'h0000_0002, rd);
      wb(1'b0, 12'h28c, '0, rd);
      `CHK(rd, 32'h0000_0000)
      repeat (8) @(posedge clock);
      esr_pin <= 3'b001;
      wait_ev(1'b0, n);
      `CHK({branch_o.trap, branch_o.vec}, 8'h85)
      $display("trap test done");
      repeat (8) @(posedge clock);
      sw_trap_valid <= 1'b1;
      sw_trap_num   <= 7'h2a;
      @(posedge clock);
      sw_trap_valid <= 1'b0;
      wait_ev(1'b0, n);
      `CHK({branch_o.trap, branch_o.vec}, 8'haa)
      repeat (8) @(posedge clock);
      wb(1'b1, 12'h028, 32'h0000_0007, rd);
      wait_ev(1'b0, n);
      `CHK({branch_o.trap, branch_o.vec}, 8'h0a)
      repeat (8) @(posedge clock);
      wb(1'b1, 12'h050, 32'h0000_000a, rd);
      wb(1'b1, 12'h078, 32'h0000_0016, rd);
      fire((96'h1 << 20) | (96'h1 << 30), 5'h00);
      wait_ev(1'b0, n);
      `CHK({branch_o.trap, branch_o.vec}, 8'h1e)
      wait_ev(1'b0, n);
      `CHK({branch_o.trap, branch_o.vec}, 8'h14)
      repeat (10) @(posedge clock);
      wb(1'b0, 12'h290, '0, rd);
      `CHK(rd[6:0], 7'h08)
      $display("request test done");
      wb(1'b1, 12'h280, 32'h0000_0002, rd);
      wb(1'b1, 12'h170, 32'h0000_0006, rd);
      alt_src <= 16'h0004;
      @(posedge clock);
      alt_src <= '0;
      wait_ev(1'b0, n);
      `CHK({branch_o.trap, branch_o.vec}, 8'h5c)
      $display("source select test done");
      repeat (8) @(posedge clock);
      wb(1'b1, 12'h284, 32'h0000_0007, rd);
      wb(1'b1, 12'h288, 32'h0000_0c40, rd);
      wb(1'b1, 12'h164, 32'h0000_0006, rd);
      // Rising edge meets the pattern, so the miss gate must hold it back
      router_pin <= 4'h1;
      wait_ev(1'b0, n);
      `CHK(n, 60)
      router_pin <= 4'h0;
      wait_ev(1'b0, n);
      `CHK(n, 10)
      `CHK({branch_o.trap, branch_o.vec}, 8'h59)
      $display("router test done");
      end_of_test();
   end
endmodule
